// ===== iap_access_port.sv
/*
  Indexed register access port: an index pointer at one host I/O address
  and a data port at the next, reaching a 128-byte internal space.
  The pointer splits into a device bit, a socket bit and a register number;
  the byte store behind the data port holds both sockets' register sets.
  Register functions themselves live in other blocks; here they are storage.
  Assumes host strobes, address, data and width are asynchronous pins and
  are each passed through two flip-flops here before any logic reads them.
  Assumes a host cycle lasts well over three core clocks: a strobe low for
  at least four clocks and high for at least three clocks between cycles.
  Assumes address and data stay stable for the whole strobe.
  Reset is the power-good input, synchronous and active high.
*/
// Behaviour
// - Pointer bits 5:0 pick one of 64 per-socket registers.
// - Pointer bit 6 selects first or second socket register set.
// - Pointer bit 7 picks which of two shared controllers responds.
// - Data port accesses transfer the addressed byte, except 00h reads the revision constant and reserved numbers read zero.
// - Pointer spans 256 locations, 64 per socket.
// - 00h-3Fh reach socket one, 40h-7Fh reach socket two.
// - Only device zero returns pointer; device one answers an index read on the upper byte only.
// - Single-socket variant implements only the first socket set.
// - Control registers at 01h-06h, window control at 07h.
// - I/O window registers at 08h-0Fh, copies at 48h upward.
// - Memory windows at 10h, 18h, 20h, 28h, 30h blocks.
// - Second socket index equals first socket index plus 40h.
// - Pointer clears to zero when power-good cycles.
`timescale 1ns/10ps
module iap_access_port #(
  // Variant: one or two sockets; which of two shared controllers this is
  parameter bit DUAL_SOCKET = 1'b1,
  parameter bit DEVICE_NUM = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [9:0] io_addr_i,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  input wire logic io_16bit_i,
  input wire logic [7:0] io_data_i,
  output logic [7:0] io_data_lo_o,
  output logic io_data_lo_oe_n_o,
  output logic [7:0] io_data_hi_o,
  output logic io_data_hi_oe_n_o,
  output logic [7:0] index_pointer_o,
  output logic reserved_access_o
);
  import iap_pkg::*;

  // All state of the port in one record, registered in one place
  typedef struct packed {
    // Strobe synchronisers and edge detectors
    logic [1:0] rd_sync;
    logic [1:0] wr_sync;
    logic rd_prev;
    logic wr_prev;
    // Address, data and width pins, two stages each, in step with the strobes
    logic [1:0][9:0] addr_sync;
    logic [1:0][7:0] data_sync;
    logic [1:0] wide_sync;
    // Access tracking and pointer
    bus_state_t state;
    logic [7:0] ptr;
    // Registered drivers; every output but the pointer comes from here
    logic [7:0] dout_lo;
    logic dout_lo_oe_n;
    logic [7:0] dout_hi;
    logic dout_hi_oe_n;
    logic reserved_hit;
  } state_t;

  // Present and next state
  state_t cur_ff;
  state_t nxt_ff;
  // Internal byte space, both sockets in every variant; socket two is unreachable from the data port when single
  logic [7:0] regs_ff [SOCKETS*SOCK_REGS];
  logic [7:0] regs_rd;
  logic rd_req;
  logic wr_req;
  logic at_index;
  logic at_data;
  logic dev_match;
  logic sock_present;
  logic reg_wr;
  // Host address, data and width after the second synchroniser stage
  logic [9:0] addr_s;
  logic [7:0] wdata_s;
  logic wide_s;

  // Index map decoder; combinational, looks only at the register number
  // Socket and device bits are handled here, so the map stays per socket
  iap_dec_if dec_bus ();
  iap_index_decode u_decode (
    .dec(dec_bus)
  );

  // Decoder sees the register number only; the map repeats per socket
  assign dec_bus.regnum = cur_ff.ptr[REGNUM_MSB:0];

  // Address and strobe edges use only the second synchroniser stage;
  // the first stage may still be settling and is read by nothing else.
  // Edge detectors start low, the idle level, so reset gives no false take
  assign rd_req = cur_ff.rd_sync[1] && !cur_ff.rd_prev;
  assign wr_req = cur_ff.wr_sync[1] && !cur_ff.wr_prev;
  // Address, data and width ride the same two-stage delay as the strobes,
  // so at the take edge they show what the host set up with the strobe
  assign addr_s = cur_ff.addr_sync[1];
  assign wdata_s = cur_ff.data_sync[1];
  assign wide_s = cur_ff.wide_sync[1];
  assign at_index = (addr_s == IO_INDEX_ADDR);
  assign at_data = (addr_s == IO_DATA_ADDR);
  // Pointer fields decide who answers at the data port; a second controller on
  // the same addresses sees the same pointer write and stays quiet there on a mismatch
  assign dev_match = (cur_ff.ptr[DEV_BIT] == DEVICE_NUM);
  assign sock_present = DUAL_SOCKET || !cur_ff.ptr[SOCK_BIT];
  assign reg_wr = wr_req && at_data && dev_match && sock_present;
  // Bit 6 plus register number forms the flat array index, so socket two
  // sits 40h above socket one; bit 7 never reaches the store
  assign regs_rd = regs_ff[{cur_ff.ptr[SOCK_BIT], cur_ff.ptr[REGNUM_MSB:0]}];

  // Next-state logic for strobe tracking, pointer and read drivers
  always_comb begin
    nxt_ff = cur_ff;
    // Pin pipelines advance every clock, whatever the state
    nxt_ff.rd_sync = {cur_ff.rd_sync[0], !io_rd_n_i};
    nxt_ff.wr_sync = {cur_ff.wr_sync[0], !io_wr_n_i};
    nxt_ff.addr_sync = {cur_ff.addr_sync[0], io_addr_i};
    nxt_ff.data_sync = {cur_ff.data_sync[0], io_data_i};
    nxt_ff.wide_sync = {cur_ff.wide_sync[0], io_16bit_i};
    nxt_ff.rd_prev = cur_ff.rd_sync[1];
    nxt_ff.wr_prev = cur_ff.wr_sync[1];
    // The reserved flag is a one-clock pulse
    nxt_ff.reserved_hit = 1'b0;
    case (cur_ff.state)
      BUS_IDLE: begin
        // One access per strobe: the take happens here, the rest of the
        // strobe is spent in BUS_ACCESS so a long strobe is not taken twice
        if (rd_req || wr_req) begin
          nxt_ff.state = BUS_ACCESS;
        end
        // Pointer writes are taken by both devices, whatever bit 7 holds,
        // since two controllers share the one index address
        if (wr_req && at_index) begin
          nxt_ff.ptr = wdata_s;
        end
        // Pointer readback: device zero answers on the low byte; device one
        // only answers a wide read, on the upper byte, with the addressed byte
        if (rd_req && at_index) begin
          if (DEVICE_NUM == 1'b0) begin
            nxt_ff.dout_lo = cur_ff.ptr;
            nxt_ff.dout_lo_oe_n = 1'b0;
          end else if (wide_s) begin
            nxt_ff.dout_hi = regs_rd; // upper byte only
            nxt_ff.dout_hi_oe_n = 1'b0;
          end
        end
        // Data port read: reserved numbers and an absent socket read as zero
        // rather than leaving the bus floating, which keeps the host's view
        // defined; the revision byte is a constant, not storage
        if (rd_req && at_data && dev_match) begin
          nxt_ff.dout_lo = 8'h00;
          if (sock_present && dec_bus.group == 4'h0) begin
            nxt_ff.dout_lo = REVISION_VALUE;
          end else if (sock_present && dec_bus.implemented) begin
            nxt_ff.dout_lo = regs_rd;
          end
          nxt_ff.dout_lo_oe_n = 1'b0;
        end
        // Reserved numbers are the host's to avoid; the flag makes a stray
        // access visible for one clock but does not stop it
        if ((rd_req || wr_req) && at_data && dev_match && !dec_bus.implemented) begin
          nxt_ff.reserved_hit = 1'b1; // flagged, not blocked
        end
      end
      BUS_ACCESS: begin
        // Drivers hold until the synchronised strobe goes inactive; the bus
        // is released about three clocks after the host lets go
        if (!cur_ff.rd_sync[1] && !cur_ff.wr_sync[1]) begin
          nxt_ff.state = BUS_IDLE;
          nxt_ff.dout_lo_oe_n = 1'b1;
          nxt_ff.dout_hi_oe_n = 1'b1;
        end
      end
      default: begin
        // Unreachable; recover to idle with both drivers off
        nxt_ff.state = BUS_IDLE;
        nxt_ff.dout_lo_oe_n = 1'b1;
        nxt_ff.dout_hi_oe_n = 1'b1;
      end
    endcase
  end

  // Single state register; synchronous power-good reset. Synchronisers and
  // edge detectors clear to the idle pin level, so no false take follows
  // a reset; data drivers start released
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
      cur_ff.state <= BUS_IDLE;
      cur_ff.ptr <= PTR_RESET;
      cur_ff.dout_lo_oe_n <= 1'b1;
      cur_ff.dout_hi_oe_n <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Byte storage; revision slot is written and read back only by device one's wide index read, reserved
  // numbers are dropped. No reset: these bytes are owned by other blocks
  // and the array stays a plain memory. Written only in the take cycle.
  always_ff @(posedge core_clk_i) begin
    if (reg_wr && dec_bus.implemented && cur_ff.state == BUS_IDLE) begin
      regs_ff[{cur_ff.ptr[SOCK_BIT], cur_ff.ptr[REGNUM_MSB:0]}] <= wdata_s;
    end
  end

  // Outputs straight from the state register; the pads' enables are
  // active low and follow the registered drivers
  assign io_data_lo_o = cur_ff.dout_lo;
  assign io_data_lo_oe_n_o = cur_ff.dout_lo_oe_n;
  assign io_data_hi_o = cur_ff.dout_hi;
  assign io_data_hi_oe_n_o = cur_ff.dout_hi_oe_n;
  assign index_pointer_o = cur_ff.ptr;
  assign reserved_access_o = cur_ff.reserved_hit;
endmodule

// ===== iap_chk.sv
/* Checker for the access port; sees only its ports. Assumes DEVICE_NUM is passed on by the bind. */
`timescale 1ns/10ps
module iap_chk import iap_pkg::*; #(parameter bit DEVICE_NUM = 1'b0) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [9:0] io_addr_i,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  input wire logic [7:0] io_data_i,
  input wire logic [7:0] io_data_lo_o,
  input wire logic io_data_lo_oe_n_o,
  input wire logic io_data_hi_oe_n_o,
  input wire logic [7:0] index_pointer_o,
  input wire logic reserved_access_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Reset must win over any pending host cycle
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=> index_pointer_o == PTR_RESET && io_data_lo_oe_n_o)
    else $error("pointer or driver not cleared by reset");
  ptr_write_a: assert property ($changed(index_pointer_o) |-> !$past(io_wr_n_i) &&
    $past(io_addr_i) == IO_INDEX_ADDR && index_pointer_o == $past(io_data_i)) else $error("pointer changed wrongly");
  read_drive_a: assert property ($fell(io_data_lo_oe_n_o) |-> !$past(io_rd_n_i)) else $error("drive without read");
  bus_release_a: assert property ($rose(io_rd_n_i) |-> ##[1:6] (io_data_lo_oe_n_o && io_data_hi_oe_n_o))
    else $error("bus not released");
  own_device_a: assert property ($fell(io_data_lo_oe_n_o) && $past(io_addr_i) == IO_DATA_ADDR |->
    index_pointer_o[DEV_BIT] == DEVICE_NUM) else $error("foreign device answered");
  ptr_readback_a: assert property ($fell(io_data_lo_oe_n_o) && $past(io_addr_i) == IO_INDEX_ADDR |->
    DEVICE_NUM == 1'b0 && io_data_lo_o == index_pointer_o) else $error("bad pointer readback");
  upper_byte_a: assert property (!io_data_hi_oe_n_o |-> DEVICE_NUM == 1'b1) else $error("upper byte driven");
  reserved_pulse_a: assert property (reserved_access_o |-> $past(io_addr_i) == IO_DATA_ADDR ##1 !reserved_access_o)
    else $error("bad reserved pulse");
endmodule
bind iap_access_port iap_chk #(.DEVICE_NUM(DEVICE_NUM)) iap_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .io_addr_i(io_addr_i), .io_rd_n_i(io_rd_n_i), .io_wr_n_i(io_wr_n_i), .io_data_i(io_data_i),
  .io_data_lo_o(io_data_lo_o), .io_data_lo_oe_n_o(io_data_lo_oe_n_o), .io_data_hi_oe_n_o(io_data_hi_oe_n_o),
  .index_pointer_o(index_pointer_o), .reserved_access_o(reserved_access_o));

// ===== iap_dec_if.sv
/*
  Carrier between the top port logic and the index map decoder.
  Assumes both ends sit on core_clk_i.
*/
`timescale 1ns/10ps
interface iap_dec_if;
  logic [5:0] regnum;
  logic implemented;
  logic [3:0] group;
  modport top (output regnum, input implemented, input group);
  modport dec (input regnum, output implemented, output group);
endinterface

// ===== iap_host.sv
/* Host processor model doing byte I/O cycles. Assumes clk_i is the core clock. */
`timescale 1ns/10ps
module iap_host (
  input wire logic clk_i,
  input wire logic [7:0] lo_i,
  input wire logic lo_oe_n_i,
  output logic [9:0] addr_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 10'h000;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wdata_o = 8'h00;
  end
  // Strobe stays low 6 clocks so sync and take land inside it; idle bus reads as pulled up.
  // Read data is looked at on falling edges, where the design's outputs have settled.
  task automatic cyc(input logic [9:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    q = 8'hff;
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_n_o = !wr;
    rd_n_o = wr;
    repeat (6) begin
      @(negedge clk_i);
      if (!wr && lo_oe_n_i === 1'b0) q = lo_i;
    end
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    wdata_o = ~d; // Released data never shows the stale byte
    repeat (5) @(negedge clk_i);
  endtask
endmodule

// ===== iap_index_decode.sv
/*
  Decodes a six-bit register number into its functional group and
  flags locations that are reserved in the internal map.
  Assumes pure combinational use from the access port.
*/
`timescale 1ns/10ps
module iap_index_decode (
  iap_dec_if.dec dec
);
  import iap_pkg::*;

  // Group codes: 0 revision, 1 control, 2 io ctrl, 3 io win, 4 mem win,
  // 5 extension, 6 ext index/data, 7 offsets, 15 reserved
  always_comb begin
    dec.group = 4'hf;
    if (dec.regnum == IDX_REVISION) begin
      dec.group = 4'h0;
    end else if (dec.regnum >= IDX_CTRL_FIRST && dec.regnum <= IDX_CTRL_LAST) begin
      dec.group = 4'h1;
    end else if (dec.regnum == IDX_IO_WIN_CTRL) begin
      dec.group = 4'h2;
    end else if (dec.regnum >= IDX_IO_WIN0 && dec.regnum < IDX_IO_WIN1 + 6'(IO_WIN_LEN)) begin
      dec.group = 4'h3;
    end else if ((dec.regnum >= IDX_MEM_WIN0 && dec.regnum < IDX_MEM_WIN0 + 6'(MEM_WIN_LEN)) ||
                 (dec.regnum >= IDX_MEM_WIN1 && dec.regnum < IDX_MEM_WIN1 + 6'(MEM_WIN_LEN)) ||
                 (dec.regnum >= IDX_MEM_WIN2 && dec.regnum < IDX_MEM_WIN2 + 6'(MEM_WIN_LEN)) ||
                 (dec.regnum >= IDX_MEM_WIN3 && dec.regnum < IDX_MEM_WIN3 + 6'(MEM_WIN_LEN)) ||
                 (dec.regnum >= IDX_MEM_WIN4 && dec.regnum < IDX_MEM_WIN4 + 6'(MEM_WIN_LEN))) begin
      dec.group = 4'h4;
    end else if (dec.regnum == IDX_MISC1 || dec.regnum == IDX_FIFO_CTRL || dec.regnum == IDX_MISC2 ||
                 dec.regnum == IDX_CHIP_INFO || dec.regnum == IDX_ATA_CTRL || dec.regnum == IDX_SCRATCH) begin
      dec.group = 4'h5;
    end else if (dec.regnum == IDX_EXT_INDEX || dec.regnum == IDX_EXT_DATA) begin
      dec.group = 4'h6;
    end else if (dec.regnum > IDX_MEM_WIN4 + 6'(MEM_WIN_LEN) - 6'h01 && dec.regnum <= IDX_IO_OFS_LAST) begin
      dec.group = 4'h7;
    end
    dec.implemented = (dec.group != 4'hf);
  end
endmodule

// ===== iap_pkg.sv
/*
  Constants for the indexed register access port: host I/O addresses,
  pointer field layout, internal index map and reset values.
  Assumes a 10-bit host I/O address and an 8-bit data path.
*/
package iap_pkg;
  localparam logic [9:0] IO_INDEX_ADDR = 10'h3e0;
  localparam logic [9:0] IO_DATA_ADDR = 10'h3e1;
  localparam int DEV_BIT = 7;
  localparam int SOCK_BIT = 6;
  localparam int REGNUM_MSB = 5;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int SOCK_REGS = 64;
  localparam int SOCKETS = 2;
  localparam logic [5:0] SOCK_STRIDE = 6'h00;
  localparam logic [7:0] SOCK_B_OFFSET = 8'h40;
  localparam logic [5:0] IDX_REVISION = 6'h00;
  localparam logic [5:0] IDX_CTRL_FIRST = 6'h01;
  localparam logic [5:0] IDX_CTRL_LAST = 6'h06;
  localparam logic [5:0] IDX_IO_WIN_CTRL = 6'h07;
  localparam logic [5:0] IDX_IO_WIN0 = 6'h08;
  localparam logic [5:0] IDX_IO_WIN1 = 6'h0c;
  localparam logic [5:0] IDX_MEM_WIN0 = 6'h10;
  localparam logic [5:0] IDX_MEM_WIN1 = 6'h18;
  localparam logic [5:0] IDX_MEM_WIN2 = 6'h20;
  localparam logic [5:0] IDX_MEM_WIN3 = 6'h28;
  localparam logic [5:0] IDX_MISC1 = 6'h16;
  localparam logic [5:0] IDX_FIFO_CTRL = 6'h17;
  localparam logic [5:0] IDX_MISC2 = 6'h1e;
  localparam logic [5:0] IDX_CHIP_INFO = 6'h1f;
  localparam logic [5:0] IDX_ATA_CTRL = 6'h26;
  localparam logic [5:0] IDX_SCRATCH = 6'h27;
  localparam logic [5:0] IDX_EXT_INDEX = 6'h2e;
  localparam logic [5:0] IDX_EXT_DATA = 6'h2f;
  localparam logic [5:0] IDX_MEM_WIN4 = 6'h30;
  localparam logic [5:0] IDX_IO_OFS_LAST = 6'h39;
  localparam logic [2:0] MEM_WIN_LEN = 3'h6;
  localparam logic [2:0] IO_WIN_LEN = 3'h4;
  // Arbitrary revision byte, not tied to any real part
  localparam logic [7:0] REVISION_VALUE = 8'h5a;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS} bus_state_t;
endpackage

// ===== tb.sv
/* Self-checking bench for the access port. Assumes one host on the bus, device 0, dual socket. */
`timescale 1ns/10ps
module tb;
  import iap_pkg::*;
  logic core_clk_i, rst_i, io_rd_n_i, io_wr_n_i, io_16bit_i, lo_oe_n, hi_oe_n, rsv;
  logic [9:0] io_addr_i;
  logic [7:0] io_data_i, lo, hi, ptr, q;
  logic [7:0] idx [7] = '{8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h28, 8'h27};
  int errors = 0;
  int cmp_count = 0;
  int rsv_count = 0;
  int hi_drives = 0;
  iap_access_port iap_access_port_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
    .io_rd_n_i(io_rd_n_i), .io_wr_n_i(io_wr_n_i), .io_16bit_i(io_16bit_i), .io_data_i(io_data_i),
    .io_data_lo_o(lo), .io_data_lo_oe_n_o(lo_oe_n), .io_data_hi_o(hi), .io_data_hi_oe_n_o(hi_oe_n),
    .index_pointer_o(ptr), .reserved_access_o(rsv));
  iap_host iap_host_inst (.clk_i(core_clk_i), .lo_i(lo), .lo_oe_n_i(lo_oe_n), .addr_o(io_addr_i),
    .rd_n_o(io_rd_n_i), .wr_n_o(io_wr_n_i), .wdata_o(io_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Reserved pulse and upper-byte drive are counted between edges, where they have settled
  always @(negedge core_clk_i) begin
    if (rsv === 1'b1) rsv_count++;
    if (!rst_i && hi_oe_n !== 1'b1) hi_drives++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Pointer write then data write
  task automatic put(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] x;
    iap_host_inst.cyc(IO_INDEX_ADDR, 1'b1, p, x);
    iap_host_inst.cyc(IO_DATA_ADDR, 1'b1, d, x);
  endtask
  // Pointer write then data read and compare
  task automatic get(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] x;
    iap_host_inst.cyc(IO_INDEX_ADDR, 1'b1, p, x);
    iap_host_inst.cyc(IO_DATA_ADDR, 1'b0, 8'h00, x);
    check(x, e);
  endtask
  initial begin
    rst_i = 1'b1;
    io_16bit_i = 1'b0;
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    iap_host_inst.cyc(IO_INDEX_ADDR, 1'b0, 8'h00, q);
    check(q, PTR_RESET);
    get(8'h00, REVISION_VALUE);
    foreach (idx[i]) begin
      put(idx[i], idx[i] ^ 8'h3c);
      put(idx[i] | SOCK_B_OFFSET, idx[i] ^ 8'hc3);
      check(ptr, idx[i] | SOCK_B_OFFSET);
    end
    foreach (idx[i]) begin
      get(idx[i], idx[i] ^ 8'h3c);
      get(idx[i] | SOCK_B_OFFSET, idx[i] ^ 8'hc3);
    end
    put(8'ha7, 8'h00);
    check(ptr, 8'ha7);
    get(8'ha7, 8'hff);
    get(8'h27, 8'h1b);
    get(8'h3a, 8'h00);
    check(8'(rsv_count), 8'h01);
    io_16bit_i = 1'b1;
    iap_host_inst.cyc(IO_INDEX_ADDR, 1'b0, 8'h00, q);
    check(q, 8'h3a);
    check(8'(hi_drives), 8'h00);
    check(hi, 8'h00);
    io_16bit_i = 1'b0;
    rst_i = 1'b1; // Second reset in mid-run
    repeat (3) @(negedge core_clk_i);
    rst_i = 1'b0;
    iap_host_inst.cyc(IO_INDEX_ADDR, 1'b0, 8'h00, q);
    check(q, PTR_RESET);
    check(ptr, PTR_RESET);
    give_verdict();
  end
  // About 70 host cycles of 12 clocks each, near 34 us; allow twice that
  initial begin
    #70us;
    errors++;
    give_verdict();
  end
endmodule
